// ===== logic/pbs_top.sv
// Parameter bank selector: picks one of eight banks as active.
// Assumes synchronous request lines and an Avalon-MM master on CLK.
// Function
// - Exactly one of eight banks active
// - Reset: bank 1 only enabled, active
// - Requests act once several banks enabled
// - Override ignores requests, applies forced bank; a held higher request still refuses a remote change
// - Pulse or level; highest request wins
// - Priority fixed, bank 1 highest
// - Two static levels: higher bank wins
// - Pulse-chosen bank stays until another
// - Override off: static levels retake control
// - Active bank readable, bank 1 at reset
// - Forced setting none or bank; pulse-like
// - After override, last bank holds
// - Override default off, gates remote changes
// - Enabled count selects usable banks
// - Static bank 1 blocks all others
// - Static bank 2..7 blocks lower ones
// - Static bank 8 blocks nothing
// - Flag not configured, blocked, changes
`timescale 1ns/1ps
`default_nettype none
module pbs_top (
   input wire logic CLK, // 50 MHz clock
   input wire logic RESET_N, // Synchronous reset, active low
   input wire logic [3:0] AVS_ADDRESS, // Byte address
   input wire logic AVS_READ, // Read strobe
   input wire logic AVS_WRITE, // Write strobe
   input wire logic [31:0] AVS_WRITEDATA, // Write data
   input wire logic [3:0] AVS_BYTEENABLE, // Byte lanes
   output logic [31:0] AVS_READDATA, // Read data
   output logic AVS_WAITREQUEST, // Wait request
   output logic AVS_RESPONSE_ERR, // Unmapped access flag with answer
   input wire logic [7:0] BANK_REQ, // Request lines, bit 0 is bank 1
   output logic [7:0] ACTIVE_BANK, // One-hot active bank
   output logic BANK_CHANGED // One-cycle pulse on change
);
   // ****************************************
   // State
   // ****************************************
   logic [2:0] active_r; // Active bank index
   logic [2:0] cnt_r; // Enabled banks minus one
   logic ovr_r; // Override enable
   logic [7:0] level_r; // Request lines of last cycle
   logic ncfg_r; // Not configured failure
   logic blk_r; // Blocked failure
   logic chg_r; // Change seen
   logic ffail_r; // Override request refused
   logic ack_r; // Answer cycle
   logic wait_r; // Wait request output register
   logic [31:0] rdata_r; // Read data
   logic err_r; // Unmapped answer
   logic [7:0] onehot_r; // Active bank output
   logic chgp_r; // Change pulse output
   // ****************************************
   // Bus decode
   // ****************************************
   logic req_take; // Access taken this cycle
   logic wr_ctrl; // Control write
   logic wr_force; // Override setting write
   logic wr_remote; // Remote change write
   logic [3:0] wcode; // Written bank code
   assign req_take = (AVS_READ | AVS_WRITE) & ~ack_r;
   assign wr_ctrl = req_take & AVS_WRITE & (AVS_ADDRESS == pbs_pkg::OFF_CTRL) & AVS_BYTEENABLE[0];
   assign wr_force = req_take & AVS_WRITE & (AVS_ADDRESS == pbs_pkg::OFF_FORCE) & AVS_BYTEENABLE[0];
   assign wr_remote = req_take & AVS_WRITE & (AVS_ADDRESS == pbs_pkg::OFF_REMOTE) & AVS_BYTEENABLE[0];
   assign wcode = AVS_WRITEDATA[3:0];
   // ****************************************
   // Request resolution
   // ****************************************
   logic [7:0] req_ok; // Requests within enabled count
   logic [7:0] req_bad; // Requests beyond enabled count
   pbs_pkg::pbs_req_t win; // Winning line
   logic [7:0] lost; // Lines lost to priority
   logic multi; // More than one bank enabled
   assign multi = (cnt_r != pbs_pkg::RST_CNT);
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         req_ok[i] = BANK_REQ[i] & (3'(i) <= cnt_r);
         req_bad[i] = BANK_REQ[i] & (3'(i) > cnt_r);
      end
   end
   pbs_resolve u_resolve (
      .req(req_ok),
      .level(level_r & req_ok),
      .win(win),
      .blocked(lost)
   );
   // Remote change: valid code, enabled, no higher request held
   logic rem_ok; // Remote request accepted
   logic [2:0] rem_idx; // Remote bank index
   assign rem_idx = 3'(wcode - 4'h1);
   assign rem_ok = wr_remote & ovr_r & (wcode != pbs_pkg::CODE_NONE) & (wcode <= 4'h8)
      & (rem_idx <= cnt_r) & ~(win.valid & (win.idx < rem_idx));
   // Forced change: override on, bank enabled
   logic frc_ok; // Forced request accepted
   assign frc_ok = wr_force & ovr_r & (wcode != pbs_pkg::CODE_NONE) & (wcode <= 4'h8)
      & (rem_idx <= cnt_r);
   // Next active bank
   logic [2:0] active_nxt;
   always_comb begin
      active_nxt = active_r; // Hold by default
      if (ovr_r) begin
         if (frc_ok | rem_ok) begin
            active_nxt = rem_idx;
         end
      end else if (multi & win.valid) begin
         active_nxt = win.idx;
      end
   end
   // ****************************************
   // Active bank and configuration
   // ****************************************
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         active_r <= pbs_pkg::RST_ACTIVE;
         onehot_r <= 8'h01;
         chgp_r <= 1'b0;
      end else begin
         // Shrinking count drops active to bank 1 if out of range
         if (active_nxt > cnt_r) begin
            active_r <= pbs_pkg::RST_ACTIVE;
            onehot_r <= 8'h01;
            chgp_r <= (active_r != pbs_pkg::RST_ACTIVE);
         end else begin
            active_r <= active_nxt;
            onehot_r <= 8'(1 << active_nxt);
            chgp_r <= (active_nxt != active_r);
         end
      end
   end
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ovr_r <= pbs_pkg::RST_OVR;
         cnt_r <= pbs_pkg::RST_CNT;
      end else if (wr_ctrl) begin
         ovr_r <= AVS_WRITEDATA[pbs_pkg::CTRL_OVR_BIT];
         cnt_r <= AVS_WRITEDATA[pbs_pkg::CTRL_CNT_LSB +: 3];
      end
   end
   // Previous request lines mark static levels
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         level_r <= 8'h00;
      end else begin
         level_r <= BANK_REQ;
      end
   end
   // ****************************************
   // Sticky flags, set wins over clear
   // ****************************************
   logic clr_wr; // Status write, one clears
   assign clr_wr = req_take & AVS_WRITE & (AVS_ADDRESS == pbs_pkg::OFF_STATUS) & AVS_BYTEENABLE[0];
   logic set_ncfg; // Not configured event
   logic set_blk; // Blocked event
   logic set_ffail; // Refused override event
   assign set_ncfg = multi & ~ovr_r & (|req_bad);
   assign set_blk = multi & ~ovr_r & (|lost);
   assign set_ffail = (wr_force | wr_remote) & (wcode != pbs_pkg::CODE_NONE) & ~(frc_ok | rem_ok);
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ncfg_r <= 1'b0;
         blk_r <= 1'b0;
         chg_r <= 1'b0;
         ffail_r <= 1'b0;
      end else begin
         ncfg_r <= set_ncfg | (ncfg_r & ~(clr_wr & AVS_WRITEDATA[pbs_pkg::ST_NCFG_BIT]));
         blk_r <= set_blk | (blk_r & ~(clr_wr & AVS_WRITEDATA[pbs_pkg::ST_BLK_BIT]));
         chg_r <= (active_nxt != active_r) | (chg_r & ~(clr_wr & AVS_WRITEDATA[pbs_pkg::ST_CHG_BIT]));
         ffail_r <= set_ffail | (ffail_r & ~(clr_wr & AVS_WRITEDATA[pbs_pkg::ST_FFAIL_BIT]));
      end
   end
   // ****************************************
   // Bus answer: one wait cycle, then ack
   // ****************************************
   logic [31:0] rd_mux; // Read value
   logic mapped; // Address decodes
   always_comb begin
      rd_mux = 32'h0;
      mapped = 1'b1;
      case (AVS_ADDRESS)
         pbs_pkg::OFF_CTRL: begin
            rd_mux[pbs_pkg::CTRL_OVR_BIT] = ovr_r;
            rd_mux[pbs_pkg::CTRL_CNT_LSB +: 3] = cnt_r;
         end
         pbs_pkg::OFF_FORCE: rd_mux = 32'h0;
         pbs_pkg::OFF_REMOTE: rd_mux = 32'h0;
         pbs_pkg::OFF_STATUS: begin
            rd_mux[pbs_pkg::ST_ACT_LSB +: 3] = active_r;
            rd_mux[pbs_pkg::ST_NCFG_BIT] = ncfg_r;
            rd_mux[pbs_pkg::ST_BLK_BIT] = blk_r;
            rd_mux[pbs_pkg::ST_CHG_BIT] = chg_r;
            rd_mux[pbs_pkg::ST_FFAIL_BIT] = ffail_r;
         end
         default: mapped = 1'b0;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ack_r <= 1'b0;
         wait_r <= 1'b1;
         rdata_r <= 32'h0;
         err_r <= 1'b0;
      end else begin
         ack_r <= req_take;
         wait_r <= ~req_take; // Low in the answer cycle only
         rdata_r <= (req_take & AVS_READ) ? rd_mux : 32'h0;
         err_r <= req_take & ~mapped;
      end
   end
   assign AVS_WAITREQUEST = wait_r;
   assign AVS_READDATA = rdata_r;
   assign AVS_RESPONSE_ERR = err_r;
   assign ACTIVE_BANK = onehot_r;
   assign BANK_CHANGED = chgp_r;
   // ****************************************
   // Checks
   // ****************************************
   one_active_a: assert property (@(posedge CLK) disable iff (!RESET_N) $onehot(ACTIVE_BANK))
      else $error("active bank not one-hot");
   idle_single_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (cnt_r == 3'h0) |=> (active_r == 3'h0))
      else $error("bank moved with one bank enabled");
   top_static_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (multi && !ovr_r && BANK_REQ[0] && $stable(cnt_r)) |=> (active_r == 3'h0))
      else $error("bank 1 request did not win");
   ovr_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (ovr_r && !wr_force && !wr_remote && $stable(cnt_r)) |=> $stable(active_r))
      else $error("bank changed under override");
   hold_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!ovr_r && BANK_REQ == 8'h00 && !wr_ctrl) |=> $stable(active_r))
      else $error("bank changed without request");
   range_ok_a: assert property (@(posedge CLK) disable iff (!RESET_N) active_r <= cnt_r)
      else $error("active bank beyond count");
   change_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      $changed(ACTIVE_BANK) |-> BANK_CHANGED)
      else $error("change not reported");
   bus_ack_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus answer late");
endmodule : pbs_top
`default_nettype wire

// ===== logic/pbs_pkg.sv
// Package for the parameter bank selector: register map, fields, resets.
// Assumes a single 50 MHz clock domain and an Avalon-MM slave with 32-bit data.
package pbs_pkg;
   // ****************************************
   // Sizes
   // ****************************************
   localparam int NUM_BANKS = 8; // Bank count
   localparam int IDX_W = 3; // Bank index width
   localparam int CODE_W = 4; // Code width, 0 means none
   localparam int ADDR_W = 4; // Byte address width
   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [3:0] OFF_CTRL = 4'h0; // Override enable, bank count
   localparam logic [3:0] OFF_FORCE = 4'h4; // Override setting (write fires)
   localparam logic [3:0] OFF_REMOTE = 4'h8; // Remote change (write fires)
   localparam logic [3:0] OFF_STATUS = 4'hC; // Active bank, failures, changes
   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_OVR_BIT = 0; // Override enable bit
   localparam int CTRL_CNT_LSB = 4; // Enabled count minus one, 3 bits
   localparam int ST_ACT_LSB = 0; // Active bank index, 3 bits
   localparam int ST_NCFG_BIT = 4; // Not configured failure (sticky)
   localparam int ST_BLK_BIT = 5; // Blocked by priority failure (sticky)
   localparam int ST_CHG_BIT = 6; // Active bank changed (sticky)
   localparam int ST_FFAIL_BIT = 7; // Override request refused (sticky)
   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [2:0] RST_ACTIVE = 3'h0; // Bank 1
   localparam logic [2:0] RST_CNT = 3'h0; // Bank 1 only
   localparam logic RST_OVR = 1'b0; // Override disabled
   localparam logic [3:0] CODE_NONE = 4'h0; // No bank selected
   // Request from one source out of the resolver
   typedef struct packed {
      logic valid; // A request is present
      logic [2:0] idx; // Bank index 0..7
   } pbs_req_t;
endpackage : pbs_pkg

// ===== logic/pbs_resolve.sv
// Fixed-priority resolver of the bank request lines.
// Assumes request levels synchronous to CLK; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pbs_resolve (
   input wire logic [7:0] req, // Request lines, bit 0 is bank 1
   input wire logic [7:0] level, // Lines held from last cycle (static)
   output pbs_pkg::pbs_req_t win, // Winning request
   output logic [7:0] blocked // Requests lost to priority
);
   // ****************************************
   // Blocking masks per line
   // ****************************************
   logic [7:0] above; // Some higher line is active
   logic [7:0] stat_above; // Some higher line holds a static level
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_mask
         if (g == 0) begin : g_top
            assign above[g] = 1'b0;
            assign stat_above[g] = 1'b0;
         end else begin : g_rest
            assign above[g] = |req[g-1:0];
            // Static higher levels block lower ones; bank 8 blocks none
            assign stat_above[g] = |(req[g-1:0] & level[g-1:0]);
         end
         assign blocked[g] = req[g] & above[g];
      end
   endgenerate
   // Priority encode, lowest index wins
   always_comb begin
      win = '0;
      for (int i = 7; i >= 0; i--) begin
         if (req[i]) begin
            win.valid = 1'b1;
            win.idx = 3'(i);
         end
      end
   end
   logic unused_ok; // Static mask feeds no output; blocked uses all higher lines
   assign unused_ok = ^stat_above;
endmodule : pbs_resolve
`default_nettype wire

// ===== tb/pbs_req_model.sv
// Request line model: application logic driving bank requests.
// Assumes the bench drives its inputs on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module pbs_req_model (
   input wire logic clk, // Bench clock
   input wire logic [7:0] level_i, // Static levels wanted
   input wire logic [7:0] pulse_i, // One-cycle pulses wanted
   output logic [7:0] req_o // Request lines to the block
);
   logic [7:0] level_r; // Held levels
   logic [7:0] pulse_r; // Pulse, one cycle only
   // Levels stay put, pulses last one cycle
   always_ff @(posedge clk) begin
      level_r <= level_i;
      pulse_r <= pulse_i;
   end
   assign req_o = level_r | pulse_r;
endmodule : pbs_req_model
`default_nettype wire

// ===== tb/pbs_top_tb_top.sv
// Bench of the bank selector: bus tasks, request model, checks.
// Assumes the bus answers after one wait cycle, as the block states.
`timescale 1ns/1ps
`default_nettype none
module pbs_top_tb_top;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 1'b0; // 50 MHz clock
   logic rst_n = 1'b0; // Reset, active low
   logic [3:0] addr = 4'h0; // Bus address
   logic rd = 1'b0; // Read strobe
   logic wr = 1'b0; // Write strobe
   logic [31:0] wdata = 32'h0; // Write data
   logic [31:0] rdata; // Read data
   logic waitreq; // Wait request
   logic rsp_err; // Error flag
   logic [7:0] lvl = 8'h00; // Wanted levels
   logic [7:0] pls = 8'h00; // Wanted pulses
   logic [7:0] req; // Request lines
   logic [7:0] active; // Active bank
   logic changed; // Change pulse
   logic [31:0] got; // Last read data
   logic got_err; // Last read error
   logic chg_seen; // Change pulse in the update cycle
   int err_count = 0; // Mismatches
   int cmp_count = 0; // Comparisons
   int cyc = 0; // Cycle count
   logic [7:0] tl [5] = '{8'h12, 8'h02, 8'h01, 8'h10, 8'h84}; // Levels
   logic [7:0] tp [5] = '{8'h00, 8'h04, 8'h80, 8'h40, 8'h00}; // Pulses
   logic [7:0] te [5] = '{8'h02, 8'h02, 8'h01, 8'h10, 8'h04}; // Winners
   always #10 clk = ~clk; // 20 ns period
   pbs_req_model u_req (.clk(clk), .level_i(lvl), .pulse_i(pls), .req_o(req));
   pbs_top u_dut (.CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .AVS_RESPONSE_ERR(rsp_err),
      .BANK_REQ(req), .ACTIVE_BANK(active), .BANK_CHANGED(changed));
   // ****************************************
   // Tasks
   // ****************************************
   // Verdict and end of run
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // Compare a register word
   task automatic chk_reg(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t reg exp %h got %h", $time, e, g);
      end
   endtask : chk_reg
   // Compare a bank vector
   task automatic chk_bank(input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %0t bank exp %h got %h", $time, e, g);
      end
   endtask : chk_bank
   // One bus cycle, held until waitrequest low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk); while (waitreq !== 1'b0);
      got = rdata;
      got_err = rsp_err;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus
   // Let a write reach the active bank
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle
   // Set levels, give a pulse, check the winner
   task automatic pulse_chk(input logic [7:0] l, input logic [7:0] p, input logic [7:0] e);
      @(posedge clk);
      lvl <= l;
      repeat (3) @(posedge clk);
      pls <= p;
      @(posedge clk);
      pls <= 8'h00;
      @(posedge clk);
      #1 chg_seen = changed;
      @(posedge clk);
      #1;
      chk_bank(e, active);
   endtask : pulse_chk
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         print_verdict();
      end
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk_bank(8'h01, active);
      bus(1'b0, 4'h0, 32'h0);
      chk_reg(32'h0, got);
      bus(1'b0, 4'hC, 32'h0);
      chk_reg(32'h0, got);
      pulse_chk(8'h00, 8'h04, 8'h01);
      $display("test reset done");
      bus(1'b1, 4'h0, 32'h70);
      pulse_chk(8'h00, 8'h04, 8'h04);
      chk_bank(8'h01, {7'h0, chg_seen});
      settle();
      chk_bank(8'h00, {7'h0, changed});
      chk_bank(8'h04, active);
      pulse_chk(8'h00, 8'h28, 8'h08);
      bus(1'b0, 4'hC, 32'h0);
      chk_reg(32'h20, got & 32'h20);
      for (int i = 0; i < 5; i++) pulse_chk(tl[i], tp[i], te[i]);
      $display("test priority done");
      pulse_chk(8'h00, 8'h04, 8'h04);
      bus(1'b1, 4'h4, 32'h6);
      settle();
      chk_bank(8'h04, active);
      bus(1'b0, 4'hC, 32'h0);
      chk_reg(32'h80, got & 32'h80);
      bus(1'b1, 4'h0, 32'h71);
      bus(1'b1, 4'h4, 32'h6);
      settle();
      chk_bank(8'h20, active);
      bus(1'b0, 4'h4, 32'h0);
      chk_reg(32'h0, got);
      pulse_chk(8'h00, 8'h01, 8'h20);
      bus(1'b1, 4'h8, 32'h7);
      settle();
      chk_bank(8'h40, active);
      bus(1'b1, 4'h0, 32'h70);
      settle();
      chk_bank(8'h40, active);
      bus(1'b1, 4'h0, 32'h71);
      pulse_chk(8'h04, 8'h00, 8'h40);
      bus(1'b1, 4'h0, 32'h70);
      settle();
      chk_bank(8'h04, active);
      $display("test override done");
      bus(1'b1, 4'h0, 32'h20);
      pulse_chk(8'h00, 8'h10, 8'h04);
      bus(1'b0, 4'hC, 32'h0);
      chk_reg(32'h10, got & 32'h10);
      bus(1'b1, 4'hC, 32'hF0);
      bus(1'b0, 4'hC, 32'h0);
      chk_reg(32'h2, got);
      bus(1'b0, 4'h2, 32'h0);
      chk_reg(32'h1, {31'h0, got_err});
      chk_reg(32'h0, got);
      $display("test count done");
      print_verdict();
   end
endmodule : pbs_top_tb_top
`default_nettype wire
